// ### hw/ssp_consts.svh
// Constants for the synchronous serial port pin logic.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// Serial word length in bits, the native data width.
`define SSP_WORD_BITS 16
// Width of the bit counter, wide enough to hold the word length.
`define SSP_CNT_BITS 5
// Core clock cycles in each half period of the master output clock.
`define SSP_MCO_HALF 4
// Width of the master output clock divider counter.
`define SSP_DIV_BITS 4
`endif

// ### hw/ssp_pkg.sv
// Types shared by the synchronous serial port pin logic.
package ssp_pkg;
	// Pin inputs that come from outside the core clock domain.
	typedef struct packed {
		logic txSerialClock;   // Transmit serial clock pin level.
		logic rxSerialClock;   // Receive serial clock pin level.
		logic txFrameSync;     // Transmit frame sync pin level.
		logic rxFrameSync;     // Receive frame sync pin level.
		logic rxSerialIn;      // Receive data pin level.
		logic testReset;       // Test reset pin, high gives scan control.
		logic emulatorPinZero; // Emulator pin zero level.
		logic disableN;        // Output disable pin, active low.
	} pinIn_t;

	// Width of the synchronised pin group.
	localparam int PIN_COUNT = $bits(pinIn_t);

	// Pin outputs and their enables, all registered.
	typedef struct packed {
		logic txSerialOut;    // Transmit data pin value.
		logic txSerialOutEn;  // Transmit data pin drive enable.
		logic txSerialClock;  // Transmit clock value when driven.
		logic txSerialClkEn;  // Transmit clock pin drive enable.
		logic txFrameSync;    // Transmit frame sync value when driven.
		logic txFrameSyncEn;  // Transmit frame sync pin drive enable.
		logic masterClockOut; // Master output clock, high in logic phase.
	} pinOut_t;
endpackage : ssp_pkg

// ### hw/sync_edge.sv
// Two-flop synchroniser with edge detection for a group of pins.
`timescale 1ns/100ps
module sync_edge #(
	parameter int WIDTH = 8 // Number of pins handled.
) (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             nrst,
	// Raw pin levels.
	input  wire logic [WIDTH-1:0] din,
	// Synchronised level and one-cycle edge pulses.
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta; // First stage, read only by the second.
	logic [WIDTH-1:0] prev; // Third stage, previous synchronised level.

	// Each pin gets its own chain; the edge flops compare the second and third stages only.
	// The chain has no reset, so it already holds true pin levels when reset ends.
	// A pin that rests high therefore shows no false rising edge after reset.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk) begin
			meta[i]  <= din[i];
			level[i] <= meta[i];
			prev[i]  <= level[i];
			if (!nrst) begin
				// Edge pulses are cleared while the chain fills.
				rise[i] <= 1'b0;
				fall[i] <= 1'b0;
			end else begin
				// Pulses come from settled stages, never from the first flop.
				rise[i] <= level[i] & ~prev[i];
				fall[i] <= ~level[i] & prev[i];
			end
		end
	end
endmodule // sync_edge

// ### hw/ssp_pins.sv
// Synchronous serial port pin logic: shifters, clock source and pin drive.
`timescale 1ns/100ps
`include "ssp_consts.svh"
// Functional notes
// - Shift transmit word out on transmit clock.
// - Clock select low: transmit clock is input.
// - Clock select high: drive clock at half master.
// - Transmit clock pin is input after reset.
// - Capture receive data on external receive clock.
// - Unused port: receive clock level readable.
// - Receive frame sync falling edge starts receive.
// - Transmit frame sync falling edge starts transmit.
// - Transmit frame sync input unless mode set.
// - Disable floats data, syncs, idle clock.
// - Disable needs test reset low, emulator high.
// - Master clock high logic, low latch phase.
module ssp_pins #(
	parameter int WORD_BITS = `SSP_WORD_BITS, // Serial word length.
	parameter int MCO_HALF  = `SSP_MCO_HALF   // Cycles per master clock half period.
) (
	// Clock and reset.
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// Raw pins from outside the clock domain.
	input  ssp_pkg::pinIn_t           pinIn,
	// Pin drive values and enables.
	output ssp_pkg::pinOut_t          pinOut,
	// Static control from the core.
	input  wire logic                 clockSourceSel,
	input  wire logic                 txSyncMode,
	input  wire logic                 portEnable,
	// Transmit word hand-off.
	input  wire logic [WORD_BITS-1:0] txWord,
	input  wire logic                 txLoad,
	output logic                      txReady,
	// Receive word hand-off.
	output logic [WORD_BITS-1:0]      rxWord,
	output logic                      rxValid,
	// Status.
	output logic                      rxClockLevel
);
	// Whole module state.
	typedef struct packed {
		logic [`SSP_DIV_BITS-1:0] divCnt;    // Master clock divider.
		logic [WORD_BITS-1:0]     txPend;    // Word waiting for a frame.
		logic                     txFree;    // No word pending, ready for a new one.
		logic [WORD_BITS-1:0]     txShift;   // Transmit shift register.
		logic [`SSP_CNT_BITS-1:0] txCnt;     // Bits left to send.
		logic                     txFsPrev;  // Frame sync at last clock fall.
		logic [WORD_BITS-1:0]     rxShift;   // Receive shift register.
		logic [`SSP_CNT_BITS-1:0] rxCnt;     // Bits left to capture.
		logic                     rxFsPrev;  // Frame sync at last clock fall.
		logic [WORD_BITS-1:0]     rxWord;    // Last completed word.
		logic                     rxValid;   // Word complete pulse.
		logic                     rxClkLvl;  // Latched receive clock level.
		logic                     offActive; // Test disable condition.
		ssp_pkg::pinOut_t         pins;      // Registered pin outputs.
	} state_t;

	state_t                          q;       // Registered state.
	state_t                          d;       // Next state.
	logic [ssp_pkg::PIN_COUNT-1:0]   lvlRaw;  // Synchronised levels.
	logic [ssp_pkg::PIN_COUNT-1:0]   riseRaw; // Synchronised rising edges.
	logic [ssp_pkg::PIN_COUNT-1:0]   fallRaw; // Synchronised falling edges.
	ssp_pkg::pinIn_t                 lvl;     // Levels by name.
	ssp_pkg::pinIn_t                 rise;    // Rising edges by name.
	ssp_pkg::pinIn_t                 fall;    // Falling edges by name.
	logic                            mcoTick; // Master clock half period over.
	logic                            txRise;  // Transmit clock rising event.
	logic                            txFall;  // Transmit clock falling event.
	logic                            txFsLvl; // Effective transmit frame sync.
	logic                            rxFall;  // Receive clock falling event.

	localparam logic [`SSP_DIV_BITS-1:0] DIV_LAST = `SSP_DIV_BITS'(MCO_HALF - 1);
	localparam logic [`SSP_CNT_BITS-1:0] CNT_FULL = `SSP_CNT_BITS'(WORD_BITS);
	localparam logic [`SSP_CNT_BITS-1:0] CNT_ONE  = `SSP_CNT_BITS'(1);

	// Every pin passes two flops before anything here looks at it.
	sync_edge #(.WIDTH(ssp_pkg::PIN_COUNT)) u_sync (
		.mclk  (mclk),
		.nrst  (nrst),
		.din   (pinIn),
		.level (lvlRaw),
		.rise  (riseRaw),
		.fall  (fallRaw)
	);

	assign lvl  = lvlRaw;
	assign rise = riseRaw;
	assign fall = fallRaw;

	// Edge events and the effective transmit frame sync.
	always_comb begin
		mcoTick = (q.divCnt == DIV_LAST);
		// Internal clock toggles on master rising edges, giving half the master rate.
		if (clockSourceSel) begin
			txRise = mcoTick & ~q.pins.masterClockOut & ~q.pins.txSerialClock;
			txFall = mcoTick & ~q.pins.masterClockOut & q.pins.txSerialClock;
		end else begin
			txRise = rise.txSerialClock;
			txFall = fall.txSerialClock;
		end
		// In output mode the own sync is used directly, saving the pin round trip.
		txFsLvl = txSyncMode ? q.pins.txFrameSync : lvl.txFrameSync;
		// The partner must keep this clock alive; a stalled clock freezes the word.
		rxFall = fall.rxSerialClock;
	end

	// Next-state logic for divider, shifters, status and pin drive.
	always_comb begin
		d = q;
		d.rxValid = 1'b0;
		// Master output clock: high half is the logic phase, low the latch phase.
		if (mcoTick) begin
			d.divCnt = '0;
			d.pins.masterClockOut = ~q.pins.masterClockOut;
			if (!q.pins.masterClockOut) begin
				d.pins.txSerialClock = ~q.pins.txSerialClock;
			end
		end else begin
			d.divCnt = q.divCnt + `SSP_DIV_BITS'(1);
		end
		// Transmit clock rising: shift the next bit out, and run the own frame sync.
		if (txRise) begin
			if (q.txCnt != '0) begin
				d.pins.txSerialOut = q.txShift[WORD_BITS-1];
				d.txShift = {q.txShift[WORD_BITS-2:0], 1'b0};
				d.txCnt = q.txCnt - CNT_ONE;
			end
			if (q.pins.txFrameSync) begin
				d.pins.txFrameSync = 1'b0;
			end else if (txSyncMode && !q.txFree && q.txCnt == '0) begin
				d.pins.txFrameSync = 1'b1;
			end
		end
		// Transmit clock falling: sample frame sync and start on its falling edge.
		if (txFall) begin
			d.txFsPrev = txFsLvl;
			if (q.txFsPrev && !txFsLvl && q.txCnt == '0) begin
				d.txShift = q.txPend;
				d.txCnt = CNT_FULL;
				d.txFree = 1'b1;
			end
		end
		// A word offered in the start cycle waits for the following frame.
		if (txLoad && q.txFree) begin
			d.txPend = txWord;
			d.txFree = 1'b0;
		end
		// Receive clock falling: capture a bit, or look for the frame start.
		if (rxFall) begin
			d.rxFsPrev = lvl.rxFrameSync;
			if (q.rxCnt != '0) begin
				d.rxShift = {q.rxShift[WORD_BITS-2:0], lvl.rxSerialIn};
				d.rxCnt = q.rxCnt - CNT_ONE;
				if (q.rxCnt == CNT_ONE) begin
					d.rxWord = {q.rxShift[WORD_BITS-2:0], lvl.rxSerialIn};
					d.rxValid = 1'b1;
				end
			end else if (q.rxFsPrev && !lvl.rxFrameSync) begin
				d.rxCnt = CNT_FULL;
			end
		end
		// Receive clock level is only tracked while the port is idle.
		if (!portEnable) begin
			d.rxClkLvl = lvl.rxSerialClock;
		end
		// Disable needs test reset low, emulator pin high and disable pin low.
		d.offActive = ~lvl.testReset & lvl.emulatorPinZero & ~lvl.disableN;
		// Pin drive enables; the receive frame sync pin is never driven.
		d.pins.txSerialOutEn = ~q.offActive;
		d.pins.txFrameSyncEn = txSyncMode & ~q.offActive;
		d.pins.txSerialClkEn = clockSourceSel & ~(q.offActive & ~portEnable);
		// Synchronous reset leaves every pin undriven and the transmit side ready.
		if (!nrst) begin
			d        = '0;
			d.txFree = 1'b1;
		end
	end

	// Single state register; its reset value is chosen in the next-state logic.
	always_ff @(posedge mclk) begin
		q <= d;
	end

	// Outputs straight from the state flops.
	assign pinOut       = q.pins;
	assign txReady      = q.txFree;
	assign rxWord       = q.rxWord;
	assign rxValid      = q.rxValid;
	assign rxClockLevel = q.rxClkLvl;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	sequence txBitSeq;
		txRise && (q.txCnt != '0);
	endsequence
	// The repeat count matches the default half period of four core cycles.
	sequence mcoHighSeq;
		$rose(q.pins.masterClockOut) ##0 q.pins.masterClockOut[*4];
	endsequence

	tx_shift_out_a: assert property (txBitSeq |=> pinOut.txSerialOut == $past(q.txShift[WORD_BITS-1]))
		else $error("Transmit bit not taken from shift register top.");
	clk_input_mode_a: assert property (!clockSourceSel |=> !pinOut.txSerialClkEn)
		else $error("Transmit clock driven while in input mode.");
	clk_half_rate_a: assert property ($changed(q.pins.txSerialClock) |-> $rose(q.pins.masterClockOut))
		else $error("Internal transmit clock moved off a master rising edge.");
	reset_undriven_a: assert property (@(posedge mclk) disable iff (1'b0)
		!nrst |=> !pinOut.txSerialClkEn && !pinOut.txFrameSyncEn)
		else $error("Pin driven right after reset.");
	rx_capture_a: assert property (rxFall && q.rxCnt != '0 |=> q.rxShift[0] == $past(lvl.rxSerialIn))
		else $error("Receive bit not captured on clock fall.");
	rx_clk_level_a: assert property (!portEnable |=> rxClockLevel == $past(lvl.rxSerialClock))
		else $error("Receive clock level not reflected while idle.");
	rx_frame_start_a: assert property (rxFall && q.rxCnt == '0 && q.rxFsPrev && !lvl.rxFrameSync
		|=> q.rxCnt == CNT_FULL)
		else $error("Receive did not start on frame sync fall.");
	// A word loaded in the start cycle is legal and keeps the ready flag low.
	tx_frame_start_a: assert property (txFall && q.txCnt == '0 && q.txFsPrev && !txFsLvl
		|=> q.txCnt == CNT_FULL && (txReady || $past(txLoad)))
		else $error("Transmit did not start on frame sync fall.");
	fs_input_mode_a: assert property (!txSyncMode |=> !pinOut.txFrameSyncEn)
		else $error("Transmit frame sync driven in input mode.");
	off_float_a: assert property (q.offActive |=> !pinOut.txSerialOutEn && !pinOut.txFrameSyncEn)
		else $error("Outputs still driven under test disable.");
	clk_off_float_a: assert property (q.offActive && !portEnable |=> !pinOut.txSerialClkEn)
		else $error("Transmit clock driven under test disable while unused.");
	off_condition_a: assert property (##1 q.offActive ==
		$past(~lvl.testReset & lvl.emulatorPinZero & ~lvl.disableN))
		else $error("Test disable state disagrees with its pins.");
	mco_phase_a: assert property (mcoHighSeq |=> !pinOut.masterClockOut)
		else $error("Master clock high phase has the wrong length.");
endmodule // ssp_pins

// ### verif/ssp_partner.sv
// Behavioural far-side serial party driving clock, frame sync and data.
`timescale 1ns/100ps
module ssp_partner (
	// Serial clock, frame sync and receive data toward the device.
	output logic      serClk,
	output logic      frameSync,
	output logic      serData,
	// Transmit data coming from the device.
	input  wire logic txData
);
	// Idle state: clock stands low and sync rests high.
	initial begin
		serClk = 1'b0;
		frameSync = 1'b1;
		serData = 1'b0;
	end

	// One frame: sync high at fall 0 and low at fall 1, bits on falls 2 to 17.
	task automatic runFrame(input logic [15:0] rxBits, output logic [15:0] txBits);
		for (int k = 0; k < 19; k++) begin
			serClk = 1'b1; // The clock runs for the whole frame only.
			frameSync = (k == 0); // Falling edge between fall 0 and fall 1.
			if (k >= 2 && k <= 17) begin
				serData = rxBits[17-k]; // Most significant bit first.
			end else begin
				serData = ~serData; // An unused data line never repeats a stale value.
			end
			#62.5;
			serClk = 1'b0;
			if (k >= 2 && k <= 17) begin
				txBits[17-k] = txData; // Device data is taken on falling edges.
			end
			#62.5;
		end
		frameSync = 1'b1;
	endtask

	// Park the clock at a level while the port is unused.
	task automatic setLevel(input logic v);
		serClk = v;
	endtask
endmodule // ssp_partner

// ### verif/sync_serial_port_pins_tb_top.sv
// Self-checking bench for the serial port pin logic.
`timescale 1ns/100ps
module sync_serial_port_pins_tb_top;
	// Clock, reset and control inputs.
	logic             mclk, nrst, clockSourceSel, txSyncMode, portEnable, txLoad;
	logic             testReset, emuZero, disableN;
	logic [15:0]      txWord;
	// Partner pins and device outputs.
	logic             serClk, frameSync, serData, txReady, rxValid, rxClockLevel;
	logic [15:0]      rxWord;
	ssp_pkg::pinIn_t  pinIn;
	ssp_pkg::pinOut_t pinOut;
	// Counters for the verdict and for receive pulses.
	int               fail_count, total_checks, rxPulses;

	// A pin driven by the device shows its value, otherwise the partner's.
	assign pinIn = {pinOut.txSerialClkEn ? pinOut.txSerialClock : serClk, serClk,
		pinOut.txFrameSyncEn ? pinOut.txFrameSync : frameSync, frameSync, serData, testReset, emuZero, disableN};

	// The default master divider, so the master clock phase check sees its four-cycle high phase.
	ssp_pins #(.WORD_BITS(16), .MCO_HALF(4)) dut (.mclk(mclk), .nrst(nrst), .pinIn(pinIn), .pinOut(pinOut),
		.clockSourceSel(clockSourceSel), .txSyncMode(txSyncMode), .portEnable(portEnable), .txWord(txWord),
		.txLoad(txLoad), .txReady(txReady), .rxWord(rxWord), .rxValid(rxValid), .rxClockLevel(rxClockLevel));
	ssp_partner partner (.serClk(serClk), .frameSync(frameSync), .serData(serData), .txData(pinOut.txSerialOut));

	// Core clock at 200 MHz.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Count the one-cycle receive pulses.
	always @(posedge mclk) begin
		if (rxValid === 1'b1) rxPulses <= rxPulses + 1;
	end

	// Move a fixed delay past an edge so inputs never race the sampling edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Compare one value and count it.
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Data, clock and sync drive enables packed as one value.
	function automatic logic [15:0] enables();
		return {13'h0, pinOut.txSerialOutEn, pinOut.txSerialClkEn, pinOut.txFrameSyncEn};
	endfunction

	// Print the verdict and stop.
	task automatic test_done();
		if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Two full-duplex frames with boundary bit patterns.
	task automatic t_frames();
		logic [15:0] words [2] = '{16'h8001, 16'h7ffe};
		logic [15:0] seen;
		int n;
		for (int i = 0; i < 2; i++) begin
			n = rxPulses;
			txWord = words[i];
			txLoad = 1'b1;
			tick(1);
			txLoad = 1'b0;
			tick(1);
			chk("txReady pending", 16'h0, {15'h0, txReady});
			partner.runFrame(~words[i], seen);
			tick(4);
			chk("tx word", words[i], seen);
			chk("rx word", ~words[i], rxWord);
			chk("rx pulses", 16'h1, 16'(rxPulses - n));
			chk("txReady free", 16'h1, {15'h0, txReady});
		end
	endtask

	// Own transmit clock runs at half the master rate; toggles are counted over 32 cycles.
	task automatic t_clock_src();
		logic pm, pt;
		int mT = 0;
		int tT = 0;
		clockSourceSel = 1'b1;
		tick(2);
		for (int i = 0; i < 32; i++) begin
			pm = pinOut.masterClockOut;
			pt = pinOut.txSerialClock;
			tick(1);
			mT += (pinOut.masterClockOut !== pm);
			tT += (pinOut.txSerialClock !== pt);
		end
		chk("clock drive", 16'h6, enables());
		chk("master toggles", 16'h8, 16'(mT));
		chk("tx clock toggles", 16'h4, 16'(tT));
		clockSourceSel = 1'b0;
		txSyncMode = 1'b1;
		tick(2);
		chk("sync drive", 16'h5, enables());
	endtask

	// Test disable floats pins only with test reset low and emulator pin high.
	task automatic t_disable();
		clockSourceSel = 1'b1;
		disableN = 1'b0;
		emuZero = 1'b1;
		tick(5);
		chk("off, port used", 16'h2, enables());
		portEnable = 1'b0;
		tick(5);
		chk("off, port unused", 16'h0, enables());
		testReset = 1'b1;
		tick(5);
		chk("scan control", 16'h7, enables());
		testReset = 1'b0;
		emuZero = 1'b0;
		tick(5);
		chk("emulator low", 16'h7, enables());
	endtask

	// The receive clock level is readable while the port is unused.
	task automatic t_rx_level();
		for (int v = 0; v < 2; v++) begin
			partner.setLevel(v == 0);
			tick(5);
			chk("rx clock level", 16'(v == 0), {15'h0, rxClockLevel});
		end
	endtask

	// Wait for a driven pin to reach a level: 0 picks the transmit clock, 1 the frame sync.
	task automatic waitPin(input int sel, input logic v);
		int t = 0;
		while ((sel == 0 ? pinOut.txSerialClock : pinOut.txFrameSync) !== v && t < 600) begin
			tick(1);
			t++;
		end
		if (t >= 600) begin // A stuck pin counts as a mismatch and ends the run.
			fail_count++;
			$display("[FAIL] pin wait expected %h seen timeout", v);
			test_done();
		end
	endtask

	// Own clock and own frame sync: the device frames and clocks one word by itself.
	task automatic t_own_frame();
		logic [15:0] seen;
		clockSourceSel = 1'b1;
		txSyncMode = 1'b1;
		portEnable = 1'b1;
		disableN = 1'b1;
		txWord = 16'ha5c3;
		txLoad = 1'b1;
		tick(1);
		txLoad = 1'b0;
		waitPin(1, 1'b1);
		waitPin(1, 1'b0);
		waitPin(0, 1'b0);
		for (int j = 15; j >= 0; j--) begin
			waitPin(0, 1'b1);
			waitPin(0, 1'b0);
			seen[j] = pinOut.txSerialOut;
		end
		chk("own tx word", 16'ha5c3, seen);
		chk("own drive", 16'h7, enables());
	endtask

	// Main sequence.
	initial begin
		{nrst, clockSourceSel, txSyncMode, txLoad, testReset, emuZero, disableN, portEnable} = 8'h03;
		{txWord, fail_count, total_checks, rxPulses} = '0;
		tick(4);
		chk("reset drive", 16'h0, {9'h0, pinOut});
		chk("reset rxWord", 16'h0, rxWord);
		chk("reset txReady", 16'h1, {15'h0, txReady});
		nrst = 1'b1;
		tick(4);
		t_frames();
		t_clock_src();
		t_disable();
		t_rx_level();
		t_own_frame();
		test_done();
	end

	// A hang counts as a mismatch.
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
endmodule // sync_serial_port_pins_tb_top
